// [sram_pkg.sv]
// constants, encodings and tap state type shared by the pipelined memory port
// assumes one 20 MHz core clock; the test clock pins are sampled, not used as a clock
// Behaviour
// - address, controls and write data are captured on the rising clock edge
// - read data leave through an output register updated on the rising edge
// - clock gate high freezes every pipeline stage as if the cycle were extended
// - reads and writes may follow back to back with no idle cycles
// - data drivers switch off synchronously during a write data phase
// - three chip selects must all be active; async output enable gates drivers
// - writes use a write strobe and per-lane write selects, done self-timed
// - bursts advance linearly or interleaved as the order pin selects
// - sleep request suspends the port; a stopped clock loses nothing
// - array holds 512K words of 36 bits or 1M words of 18 bits
// - driver enable is timed internally, no output enable toggling needed
// - a test access port with only id code and bypass data registers is provided
package sram_pkg;
	localparam int          LANE_W       = 9;             // bits per byte lane
	localparam int          LANES_WIDE   = 4;             // 36-bit organisation
	localparam int          LANES_NARROW = 2;             // 18-bit organisation
	localparam int          ADDR_W_WIDE  = 19;            // 512K words
	localparam int          ADDR_W_NARROW = 20;           // 1M words
	localparam int          BURST_W      = 2;             // four-beat burst counter
	localparam int          DATA_LATENCY = 2;             // command edge to data edge
	localparam logic [1:0]  BURST_START  = 2'h0;
	localparam logic [1:0]  BURST_STEP   = 2'h1;
	localparam int          IR_W         = 3;
	localparam logic [2:0]  IR_EXTEST    = 3'h0;
	localparam logic [2:0]  IR_IDCODE    = 3'h1;
	localparam logic [2:0]  IR_SAMPLE    = 3'h4;
	localparam logic [2:0]  IR_BYPASS    = 3'h7;
	localparam logic [2:0]  IR_CAPTURE   = 3'h1;          // pattern loaded on ir capture
	localparam int          DR_W         = 32;
	localparam logic [31:0] ID_DEFAULT   = 32'h0A5A_5001; // arbitrary value, lsb fixed at one
	localparam int          SYNC_N       = 5;             // sampled pins
	localparam int          S_SLEEP      = 0;
	localparam int          S_ORDER      = 1;
	localparam int          S_TCK        = 2;
	localparam int          S_TMS        = 3;
	localparam int          S_TDI        = 4;

	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
	} tap_state_e;
endpackage : sram_pkg

// [mem_port_if.sv]
// array access signals between the pipeline control and the storage module
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface mem_port_if #(
	parameter int ADDR_W = 19,
	parameter int LANES  = 4
);
	logic                            rd_en;
	logic [ADDR_W-1:0]               rd_addr;
	logic [LANES*sram_pkg::LANE_W-1:0] rd_data;
	logic                            wr_en;
	logic [ADDR_W-1:0]               wr_addr;
	logic [LANES-1:0]                wr_lane;
	logic [LANES*sram_pkg::LANE_W-1:0] wr_data;

	modport ctrl  (output rd_en, rd_addr, wr_en, wr_addr, wr_lane, wr_data, input rd_data);
	modport array (input rd_en, rd_addr, wr_en, wr_addr, wr_lane, wr_data, output rd_data);
endinterface : mem_port_if

// [lane_array.sv]
// per-lane storage with a registered read port and write-to-read forwarding
// assumes strobes come from the pipeline control on the same clock
`timescale 1ns/1ps
module lane_array #(
	parameter int ADDR_W = 19,
	parameter int LANES  = 4
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	mem_port_if.array p
);
	localparam int W = sram_pkg::LANE_W;

	// one memory and one output register per byte lane
	for (genvar g = 0; g < LANES; g++)
	begin : lane
		logic [W-1:0] mem [0:(1<<ADDR_W)-1];
		logic [W-1:0] rd_q;
		logic [W-1:0] rd_d;

		// read, taking the lane of a write landing at the same edge
		always_comb
		begin
			rd_d = rd_q;
			if (p.rd_en)
			begin
				rd_d = mem[p.rd_addr];
				if (p.wr_en && p.wr_lane[g] && p.wr_addr == p.rd_addr)
					rd_d = p.wr_data[g*W +: W];
			end
		end

		// output register of the read path
		always_ff @(posedge core_clk or negedge rst_b)
		begin
			if (!rst_b)
				rd_q <= '0;
			else
				rd_q <= rd_d;
		end

		// self-timed lane write
		always_ff @(posedge core_clk)
		begin
			if (p.wr_en && p.wr_lane[g])
				mem[p.wr_addr] <= p.wr_data[g*W +: W];
		end

		assign p.rd_data[g*W +: W] = rd_q;
	end
endmodule : lane_array

// [pipelined_sync_sram_port.sv]
// synchronous pipelined burst memory port with byte writes, sleep and a test access port
// assumes the controller runs on core_clk; sleep, order and test pins arrive unsynchronised
`timescale 1ns/1ps
module pipelined_sync_sram_port #(
	parameter int          ADDR_W = sram_pkg::ADDR_W_WIDE,
	parameter int          LANES  = sram_pkg::LANES_WIDE,
	parameter logic [31:0] ID_VAL = sram_pkg::ID_DEFAULT
) (
	input  wire logic                            core_clk,
	input  wire logic                            rst_b,
	input  wire logic [ADDR_W-1:0]               addr,
	input  wire logic                            load_n,
	input  wire logic                            write_n,
	input  wire logic [LANES-1:0]                byte_lane_write_n,
	input  wire logic                            select_low_one,
	input  wire logic                            select_high,
	input  wire logic                            select_low_two,
	input  wire logic                            clock_gate_n,
	input  wire logic                            out_en_n,
	input  wire logic                            sleep_request,
	input  wire logic                            burst_interleave,
	input  wire logic [LANES*sram_pkg::LANE_W-1:0] dq_in,
	output logic      [LANES*sram_pkg::LANE_W-1:0] dq_out,
	output logic                                 dq_oe_n,
	input  wire logic                            tck,
	input  wire logic                            tms,
	input  wire logic                            tdi,
	output logic                                 tdo,
	output logic                                 tdo_oe_n
);
	localparam int BW = sram_pkg::BURST_W;

	logic [sram_pkg::SYNC_N-1:0] sync1_q;
	logic [sram_pkg::SYNC_N-1:0] sync2_q;
	logic                        sleep_s;
	logic                        advance;
	logic                        c1_valid_q, c1_valid_d;
	logic                        c1_write_q, c1_write_d;
	logic [ADDR_W-1:0]           c1_addr_q,  c1_addr_d;
	logic [LANES-1:0]            c1_lanes_q, c1_lanes_d;
	logic [ADDR_W-1:0]           base_q,     base_d;
	logic [BW-1:0]               cnt_q,      cnt_d;
	logic                        c2_valid_q, c2_valid_d;
	logic                        c2_write_q, c2_write_d;
	logic [ADDR_W-1:0]           c2_addr_q,  c2_addr_d;
	logic [LANES-1:0]            c2_lanes_q, c2_lanes_d;
	logic                        rd_drive_q, rd_drive_d;
	logic [BW-1:0]               beat;

	mem_port_if #(.ADDR_W(ADDR_W), .LANES(LANES)) mp ();

	// two-flop samplers for pins outside the controller's timing
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {tdi, tms, tck, burst_interleave, sleep_request};
			sync2_q <= sync1_q;
		end
	end

	assign sleep_s = sync2_q[sram_pkg::S_SLEEP];
	// the pipeline moves only on edges the gate lets through and outside sleep
	assign advance = !clock_gate_n && !sleep_s;

	// burst beat order: linear adds, interleaved toggles address bits
	always_comb
	begin
		beat = cnt_q + sram_pkg::BURST_STEP;
		if (sync2_q[sram_pkg::S_ORDER])
			beat = base_q[BW-1:0] ^ beat;
		else
			beat = base_q[BW-1:0] + beat;
	end

	// next values of the command pipeline
	always_comb
	begin
		c1_valid_d = c1_valid_q;
		c1_write_d = c1_write_q;
		c1_addr_d  = c1_addr_q;
		c1_lanes_d = c1_lanes_q;
		base_d     = base_q;
		cnt_d      = cnt_q;
		c2_valid_d = c2_valid_q;
		c2_write_d = c2_write_q;
		c2_addr_d  = c2_addr_q;
		c2_lanes_d = c2_lanes_q;
		rd_drive_d = rd_drive_q;
		if (advance)
		begin
			if (!load_n)
			begin
				c1_valid_d = !select_low_one && select_high && !select_low_two;
				c1_write_d = !write_n;
				c1_addr_d  = addr;
				base_d     = addr;
				cnt_d      = sram_pkg::BURST_START;
			end
			else
			begin
				cnt_d     = cnt_q + sram_pkg::BURST_STEP;
				c1_addr_d = {base_q[ADDR_W-1:BW], beat};
			end
			c1_lanes_d = ~byte_lane_write_n;
			c2_valid_d = c1_valid_q;
			c2_write_d = c1_write_q;
			c2_addr_d  = c1_addr_q;
			c2_lanes_d = c1_lanes_q;
			rd_drive_d = c1_valid_q && !c1_write_q;
		end
	end

	// command pipeline registers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			c1_valid_q <= 1'b0;
			c1_write_q <= 1'b0;
			c1_addr_q  <= '0;
			c1_lanes_q <= '0;
			base_q     <= '0;
			cnt_q      <= '0;
			c2_valid_q <= 1'b0;
			c2_write_q <= 1'b0;
			c2_addr_q  <= '0;
			c2_lanes_q <= '0;
			rd_drive_q <= 1'b0;
		end
		else
		begin
			c1_valid_q <= c1_valid_d;
			c1_write_q <= c1_write_d;
			c1_addr_q  <= c1_addr_d;
			c1_lanes_q <= c1_lanes_d;
			base_q     <= base_d;
			cnt_q      <= cnt_d;
			c2_valid_q <= c2_valid_d;
			c2_write_q <= c2_write_d;
			c2_addr_q  <= c2_addr_d;
			c2_lanes_q <= c2_lanes_d;
			rd_drive_q <= rd_drive_d;
		end
	end

	// array strobes: read one edge after capture, write data taken two edges after
	assign mp.rd_en   = advance && c1_valid_q && !c1_write_q;
	assign mp.rd_addr = c1_addr_q;
	assign mp.wr_en   = advance && c2_valid_q && c2_write_q;
	assign mp.wr_addr = c2_addr_q;
	assign mp.wr_lane = c2_lanes_q;
	assign mp.wr_data = dq_in;

	lane_array #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES)
	) u_array (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.p        (mp)
	);

	// data pins: registered data, drivers on only for a read data phase
	assign dq_out  = mp.rd_data;
	assign dq_oe_n = !(rd_drive_q && !out_en_n && !sleep_s);

	// test access port, stepped on sampled test clock edges
	sram_pkg::tap_state_e        tap_q, tap_d;
	logic                        tck_prev_q;
	logic                        tck_rise;
	logic                        tck_fall;
	logic [sram_pkg::IR_W-1:0]   ir_q, ir_d;
	logic [sram_pkg::IR_W-1:0]   irsh_q, irsh_d;
	logic [sram_pkg::DR_W-1:0]   dr_q, dr_d;
	logic                        tdo_q, tdo_d;
	logic                        tdo_oe_n_q, tdo_oe_n_d;
	logic                        t_ms;
	logic                        t_di;

	assign tck_rise = sync2_q[sram_pkg::S_TCK] && !tck_prev_q;
	assign tck_fall = !sync2_q[sram_pkg::S_TCK] && tck_prev_q;
	assign t_ms     = sync2_q[sram_pkg::S_TMS];
	assign t_di     = sync2_q[sram_pkg::S_TDI];

	// tap state walk, register capture and shift
	always_comb
	begin
		tap_d      = tap_q;
		ir_d       = ir_q;
		irsh_d     = irsh_q;
		dr_d       = dr_q;
		tdo_d      = tdo_q;
		tdo_oe_n_d = tdo_oe_n_q;
		if (tck_rise)
		begin
			unique case (tap_q)
				sram_pkg::TAP_RESET:  tap_d = t_ms ? sram_pkg::TAP_RESET  : sram_pkg::TAP_IDLE;
				sram_pkg::TAP_IDLE:   tap_d = t_ms ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
				sram_pkg::TAP_SEL_DR: tap_d = t_ms ? sram_pkg::TAP_SEL_IR : sram_pkg::TAP_CAP_DR;
				sram_pkg::TAP_CAP_DR: tap_d = t_ms ? sram_pkg::TAP_EX1_DR : sram_pkg::TAP_SH_DR;
				sram_pkg::TAP_SH_DR:  tap_d = t_ms ? sram_pkg::TAP_EX1_DR : sram_pkg::TAP_SH_DR;
				sram_pkg::TAP_EX1_DR: tap_d = t_ms ? sram_pkg::TAP_UP_DR  : sram_pkg::TAP_PA_DR;
				sram_pkg::TAP_PA_DR:  tap_d = t_ms ? sram_pkg::TAP_EX2_DR : sram_pkg::TAP_PA_DR;
				sram_pkg::TAP_EX2_DR: tap_d = t_ms ? sram_pkg::TAP_UP_DR  : sram_pkg::TAP_SH_DR;
				sram_pkg::TAP_UP_DR:  tap_d = t_ms ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
				sram_pkg::TAP_SEL_IR: tap_d = t_ms ? sram_pkg::TAP_RESET  : sram_pkg::TAP_CAP_IR;
				sram_pkg::TAP_CAP_IR: tap_d = t_ms ? sram_pkg::TAP_EX1_IR : sram_pkg::TAP_SH_IR;
				sram_pkg::TAP_SH_IR:  tap_d = t_ms ? sram_pkg::TAP_EX1_IR : sram_pkg::TAP_SH_IR;
				sram_pkg::TAP_EX1_IR: tap_d = t_ms ? sram_pkg::TAP_UP_IR  : sram_pkg::TAP_PA_IR;
				sram_pkg::TAP_PA_IR:  tap_d = t_ms ? sram_pkg::TAP_EX2_IR : sram_pkg::TAP_PA_IR;
				sram_pkg::TAP_EX2_IR: tap_d = t_ms ? sram_pkg::TAP_UP_IR  : sram_pkg::TAP_SH_IR;
				sram_pkg::TAP_UP_IR:  tap_d = t_ms ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
			endcase
			unique case (tap_q)
				sram_pkg::TAP_RESET:  ir_d = sram_pkg::IR_IDCODE;
				sram_pkg::TAP_CAP_IR: irsh_d = sram_pkg::IR_CAPTURE;
				sram_pkg::TAP_SH_IR:  irsh_d = {t_di, irsh_q[sram_pkg::IR_W-1:1]};
				sram_pkg::TAP_UP_IR:  ir_d = irsh_q;
				sram_pkg::TAP_CAP_DR: dr_d = (ir_q == sram_pkg::IR_IDCODE) ? ID_VAL : '0;
				sram_pkg::TAP_SH_DR:
				begin
					if (ir_q == sram_pkg::IR_IDCODE)
						dr_d = {t_di, dr_q[sram_pkg::DR_W-1:1]};
					else
						dr_d = {{(sram_pkg::DR_W-1){1'b0}}, t_di}; // one-bit bypass path
				end
				default: ;
			endcase
		end
		// tdo moves on the falling test clock edge, driven only while shifting
		if (tck_fall)
		begin
			tdo_oe_n_d = !(tap_q == sram_pkg::TAP_SH_DR || tap_q == sram_pkg::TAP_SH_IR);
			tdo_d      = (tap_q == sram_pkg::TAP_SH_IR) ? irsh_q[0] : dr_q[0];
		end
	end

	// test access port registers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tap_q      <= sram_pkg::TAP_RESET;
			tck_prev_q <= 1'b0;
			ir_q       <= sram_pkg::IR_IDCODE;
			irsh_q     <= '0;
			dr_q       <= '0;
			tdo_q      <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end
		else
		begin
			tap_q      <= tap_d;
			tck_prev_q <= sync2_q[sram_pkg::S_TCK];
			ir_q       <= ir_d;
			irsh_q     <= irsh_d;
			dr_q       <= dr_d;
			tdo_q      <= tdo_d;
			tdo_oe_n_q <= tdo_oe_n_d;
		end
	end

	assign tdo      = tdo_q;
	assign tdo_oe_n = tdo_oe_n_q;
endmodule : pipelined_sync_sram_port

// [ctrl_model.sv]
// controller model: presents write data one advancing edge after the command
// assumes the bench hands it each command at the edge the port takes it
`timescale 1ns/1ps
module ctrl_model #(
	parameter int W = 36
) (
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	input  wire logic         adv,
	input  wire logic         wr_now,
	input  wire logic [W-1:0] wr_data,
	output logic      [W-1:0] dq_in
);
	logic         wr_q;
	logic [W-1:0] dat_q;
	// data phase trails the command; a released bus toggles; stalls hold everything
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_q  <= 1'b0;
			dat_q <= '0;
			dq_in <= '0;
		end
		else if (adv)
		begin
			wr_q  <= wr_now;
			dat_q <= wr_data;
			dq_in <= wr_q ? dat_q : ~dq_in;
		end
	end
endmodule : ctrl_model

// [sram_port_properties.sv]
// pin-level assertions for the pipelined memory port
// assumes the bind below; the sleep pin passes a two-flop synchroniser inside
`timescale 1ns/1ps
module sram_port_properties #(
	parameter int LANES = 4
) (
	input wire logic                              core_clk,
	input wire logic                              rst_b,
	input wire logic                              load_n,
	input wire logic                              write_n,
	input wire logic                              select_low_one,
	input wire logic                              select_high,
	input wire logic                              select_low_two,
	input wire logic                              clock_gate_n,
	input wire logic                              out_en_n,
	input wire logic                              sleep_request,
	input wire logic [LANES*sram_pkg::LANE_W-1:0] dq_out,
	input wire logic                              dq_oe_n
);
	logic [2:0] sl_q;
	logic [2:0] sl_d;
	logic       go;
	logic       sel;
	logic       rd;
	logic       wr;
	// recent sleep samples
	always_comb sl_d = {sl_q[1:0], sleep_request};
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			sl_q <= 3'h0;
		else
			sl_q <= sl_d;
	end
	// advancing edge and decoded loads
	assign go  = !clock_gate_n && !sleep_request && sl_q == 3'h0;
	assign sel = !select_low_one && select_high && !select_low_two;
	assign rd  = go && !load_n && sel && write_n;
	assign wr  = go && !load_n && sel && !write_n;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_oe_gate;
		out_en_n |-> dq_oe_n;
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("driver on while output enable off");
	property p_wr_float;
		wr ##1 go |=> dq_oe_n;
	endproperty
	a_wr_float: assert property (p_wr_float) else $error("driver on in write data phase");
	property p_desel;
		go && !load_n && !sel ##1 go |=> dq_oe_n;
	endproperty
	a_desel: assert property (p_desel) else $error("driver on after deselect");
	property p_rd_lat;
		rd ##1 go |=> out_en_n || !dq_oe_n;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data not driven in its phase");
	property p_gate_dat;
		clock_gate_n && $past(rst_b) |=> $stable(dq_out);
	endproperty
	a_gate_dat: assert property (p_gate_dat) else $error("read data moved on gated edge");
	property p_gate_oe;
		clock_gate_n && !out_en_n && sl_q == 3'h0 && !sleep_request ##1 !out_en_n |-> $stable(dq_oe_n);
	endproperty
	a_gate_oe: assert property (p_gate_oe) else $error("driver enable moved on gated edge");
	property p_sleep;
		sl_q == 3'h7 && sleep_request |-> dq_oe_n;
	endproperty
	a_sleep: assert property (p_sleep) else $error("driver on during sleep");
	property p_release;
		$rose(rst_b) |-> dq_oe_n && dq_out == '0;
	endproperty
	a_release: assert property (p_release) else $error("outputs not cleared by reset");
	c_read: cover property (rd ##1 go ##1 !dq_oe_n);
	c_ww: cover property (wr ##1 wr);
	c_stall: cover property (clock_gate_n ##1 clock_gate_n);
endmodule : sram_port_properties
bind pipelined_sync_sram_port sram_port_properties #(.LANES(LANES)) u_props (
	.core_clk(core_clk), .rst_b(rst_b), .load_n(load_n), .write_n(write_n),
	.select_low_one(select_low_one), .select_high(select_high), .select_low_two(select_low_two),
	.clock_gate_n(clock_gate_n), .out_en_n(out_en_n), .sleep_request(sleep_request),
	.dq_out(dq_out), .dq_oe_n(dq_oe_n));

// [tb_top.sv]
// self-checking bench for the pipelined memory port: random traffic and corner cases
// assumes the controller model supplies write data; test pins walk the id register out at the end
`timescale 1ns/1ps
module tb_top;
	localparam int AW = sram_pkg::ADDR_W_WIDE;
	localparam int LN = sram_pkg::LANES_WIDE;
	localparam int LW = sram_pkg::LANE_W;
	localparam int DW = LN * LW;
	typedef struct packed {
		logic [1:0]    k;
		logic [AW-1:0] a;
		logic [LN-1:0] l;
		logic [DW-1:0] d;
	} cmd_s;
	logic          core_clk;
	logic          rst_b;
	logic [AW-1:0] addr;
	logic          load_n;
	logic          write_n;
	logic [LN-1:0] byte_lane_write_n;
	logic          select_low_one;
	logic          select_high;
	logic          select_low_two;
	logic          clock_gate_n;
	logic          out_en_n;
	logic          sleep_request;
	logic          burst_interleave;
	logic [DW-1:0] dq_in;
	logic [DW-1:0] dq_out;
	logic          dq_oe_n;
	logic          adv;
	logic [1:0]    slp_q = 2'h0;
	logic          tck;
	logic          tms;
	logic          tdi;
	logic          tdo;
	logic          tdo_oe_n;
	cmd_s          cmd;
	cmd_s          s1;
	cmd_s          s2;
	logic [DW-1:0] mem [int];
	logic [AW-1:0] pool [8];
	int            bad_count;
	int            tests_run;
	// the port sees sleep through two flops, so its stalls start and end two edges late
	assign adv = !clock_gate_n && !slp_q[1];
	always @(posedge core_clk)
		slp_q <= {slp_q[0], sleep_request};
	pipelined_sync_sram_port DUT (
		.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .load_n(load_n), .write_n(write_n),
		.byte_lane_write_n(byte_lane_write_n), .select_low_one(select_low_one), .select_high(select_high),
		.select_low_two(select_low_two), .clock_gate_n(clock_gate_n), .out_en_n(out_en_n),
		.sleep_request(sleep_request), .burst_interleave(burst_interleave), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
	ctrl_model #(.W(DW)) u_ctrl (.core_clk(core_clk), .rst_b(rst_b), .adv(adv),
		.wr_now(cmd.k == 2'h2), .wr_data(cmd.d), .dq_in(dq_in));
	// lane-wise merge of a write into the old word
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n, input logic [LN-1:0] l);
		logic [DW-1:0] r;
		r = o;
		for (int g = 0; g < LN; g++)
			if (!l[g])
				r[g*LW +: LW] = n[g*LW +: LW];
		return r;
	endfunction : merge
	// burst beat address, linear or interleaved in the low two bits
	function automatic logic [AW-1:0] baddr(input logic [AW-1:0] b, input int n, input logic il);
		logic [1:0] lo;
		lo = il ? (b[1:0] ^ 2'(n)) : (b[1:0] + 2'(n));
		return {b[AW-1:2], lo};
	endfunction : baddr
	task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// one bus cycle; s holds the raw select pins {low one, high, low two}
	task automatic cyc(input logic ld, input logic [1:0] k, input logic [AW-1:0] a, input logic [LN-1:0] l,
		input logic [2:0] s, input logic g, input logic oe);
		cmd_s x;
		x.k = (s == 3'b010) ? k : 2'h0;
		x.a = a;
		x.l = l;
		x.d = DW'({$urandom, $urandom});
		@(posedge core_clk);
		load_n <= !ld;
		write_n <= (k != 2'h2);
		addr <= a;
		byte_lane_write_n <= l;
		{select_low_one, select_high, select_low_two} <= s;
		clock_gate_n <= g;
		out_en_n <= oe;
		cmd <= x;
	endtask : cyc
	task automatic idle;
		cyc(1'b1, 2'h0, '0, '1, 3'b101, 1'b0, 1'b0);
	endtask : idle
	// one slow test clock period; tdo has settled by the return
	task automatic tclk(input logic m, input logic d);
		tms <= m;
		tdi <= d;
		repeat (6) @(posedge core_clk);
		tck <= 1'b1;
		repeat (6) @(posedge core_clk);
		tck <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask : tclk
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// reference pipeline: check each data phase, retire it on advancing edges
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			s1 = '0;
			s2 = '0;
		end
		if (s2.k == 2'h1 && !out_en_n && !slp_q[1])
		begin
			chk("dq_oe_n", DW'(0), DW'(dq_oe_n));
			chk("dq_out", mem[s2.a], dq_out);
		end
		else
			chk("dq_oe_n", DW'(1), DW'(dq_oe_n));
		if (adv && rst_b)
		begin
			if (s2.k == 2'h2)
				mem[s2.a] = merge(mem[s2.a], s2.d, s2.l);
			s2 = s1;
			s1 = cmd;
		end
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		stop_test();
	end
	initial
	begin
		logic [AW-1:0] base;
		// load high, write high, selects off, gate, enable, sleep and order low
		{load_n, write_n, select_low_one, select_high, select_low_two} = 5'h1D;
		{clock_gate_n, out_en_n, sleep_request, burst_interleave} = 4'h0;
		rst_b = 1'b0;
		addr = '0;
		byte_lane_write_n = '1;
		{tck, tms, tdi} = 3'h0;
		cmd = '0;
		s1 = '0;
		s2 = '0;
		bad_count = 0;
		tests_run = 0;
		void'($urandom(32'h7784));
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		base = AW'($urandom) & ~AW'(7);
		for (int i = 0; i < 8; i++)
		begin
			pool[i] = base + AW'(i);
			cyc(1'b1, 2'h2, pool[i], '0, 3'b010, 1'b0, 1'b0);
		end
		cyc(1'b1, 2'h2, pool[0], 4'h5, 3'b010, 1'b0, 1'b0);
		cyc(1'b1, 2'h1, pool[0], '1, 3'b010, 1'b0, 1'b0);
		for (int i = 0; i < 80; i++)
			cyc(1'b1, 2'($urandom_range(2, 1)), pool[$urandom_range(7)], LN'($urandom),
				($urandom_range(3) != 0) ? 3'b010 : 3'($urandom),
				$urandom_range(4) == 0, $urandom_range(6) == 0);
		repeat (4) idle();
		cyc(1'b1, 2'h1, pool[3], '1, 3'b010, 1'b0, 1'b0);
		sleep_request <= 1'b1;
		repeat (6) idle();
		sleep_request <= 1'b0;
		repeat (4) idle();
		cyc(1'b1, 2'h1, pool[2], '1, 3'b010, 1'b0, 1'b0);
		for (int m = 0; m < 2; m++)
		begin
			burst_interleave <= m[0];
			repeat (3) idle();
			cyc(1'b1, 2'h1, pool[1], '1, 3'b010, 1'b0, 1'b0);
			for (int n = 1; n < 6; n++)
				cyc(1'b0, 2'h1, baddr(pool[1], n, m[0]), '1, 3'b010, 1'b0, 1'b0);
		end
		repeat (4) idle();
		// idle, select-dr, capture-dr, then shift the id register out lsb first
		tclk(1'b0, 1'b0);
		tclk(1'b1, 1'b0);
		tclk(1'b0, 1'b0);
		chk("tdo_oe_n", DW'(1), DW'(tdo_oe_n));
		for (int i = 0; i < sram_pkg::DR_W; i++)
		begin
			tclk(1'b0, 1'b0);
			chk("tdo_oe_n", DW'(0), DW'(tdo_oe_n));
			chk("tdo", DW'(sram_pkg::ID_DEFAULT[i]), DW'(tdo));
		end
		stop_test();
	end
endmodule : tb_top
